// ===== common/timer_cfg_pkg.sv
package timer_cfg_pkg;

    // Sizes
    localparam int NUM_CH = 3;
    localparam int NUM_GR = 4;
    localparam int NUM_EXT = 4;
    localparam int PRE_W = 10;

    // Prescaler taps: low bits that must all be set for one tick
    localparam int DIV4_BITS = 2;
    localparam int DIV16_BITS = 4;
    localparam int DIV64_BITS = 6;
    localparam int DIV256_BITS = 8;
    localparam int DIV1024_BITS = 10;

    // Register offsets
    localparam logic [7:0] START_OFS = 8'h00;
    localparam logic [7:0] SYNC_OFS = 8'h01;
    localparam logic [1:0] CH0_PAGE = 2'h1;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] MODE_OFS = 4'h1;
    localparam logic [3:0] COUNT_OFS = 4'h2;
    localparam logic [3:0] GR_A_OFS = 4'h4;
    localparam logic [3:0] GR_D_OFS = 4'h7;

    // Field positions
    localparam int CLR_LSB = 5;
    localparam int CLR_MSB = 7;
    localparam int PSC_LSB = 0;
    localparam int PSC_MSB = 2;
    localparam int BUF_B_BIT = 5;
    localparam int BUF_A_BIT = 4;
    localparam int OPM_LSB = 0;
    localparam int OPM_MSB = 3;

    // Reset values and fixed bits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'hc0;
    localparam logic [7:0] MODE_ONES = 8'hc0;
    localparam logic [7:0] CTRL_CH12_MASK = 8'h7f;
    localparam logic [7:0] MODE_CH0_MASK = 8'h3f;
    localparam logic [7:0] MODE_CH12_MASK = 8'h0f;
    localparam logic [15:0] GR_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Counter clear source
    typedef enum logic [2:0] {
        CLR_NONE = 3'b000,
        CLR_A = 3'b001,
        CLR_B = 3'b010,
        CLR_SYNC = 3'b011,
        CLR_NONE2 = 3'b100,
        CLR_C = 3'b101,
        CLR_D = 3'b110,
        CLR_SYNC2 = 3'b111
    } clr_sel_t;

    // Operating mode field
    typedef enum logic [3:0] {
        OPM_NORMAL = 4'b0000,
        OPM_RESERVED = 4'b0001,
        OPM_PWM1 = 4'b0010,
        OPM_PWM2 = 4'b0011,
        OPM_PHASE1 = 4'b0100,
        OPM_PHASE2 = 4'b0101,
        OPM_PHASE3 = 4'b0110,
        OPM_PHASE4 = 4'b0111
    } op_mode_t;

endpackage

// ===== hw/pin_sync.sv
module pin_sync
    import timer_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins
    input wire logic [NUM_EXT-1:0] pin_raw,
    // Synchronised level and rising-edge pulse
    output logic [NUM_EXT-1:0] pin_level,
    output logic [NUM_EXT-1:0] pin_rise
);

    logic [NUM_EXT-1:0] stage1;
    logic [NUM_EXT-1:0] stage2;
    logic [NUM_EXT-1:0] stage3;

    ////////////////////////////////////////////////////////////////////////////
    // Two flops, then an edge register
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin_raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign pin_level = stage2;
    assign pin_rise = stage2 & ~stage3;

endmodule // pin_sync

// ===== hw/timer_channel_clock_clear_mode_config.sv
// Strobed register access and the register offsets were decided locally.
module timer_channel_clock_clear_mode_config
    import timer_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // External clock pins
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    // Events
    output logic [NUM_CH*NUM_GR-1:0] compare_match,
    output logic [NUM_CH-1:0] counter_cleared
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic div_tick(input logic [PRE_W-1:0] pre, input int bits);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < bits) begin
                hit = hit & pre[i];
            end
        end
        return hit;
    endfunction

    function automatic logic clock_tick(input int ch, input logic [2:0] psc,
                                        input logic [PRE_W-1:0] pre, input logic [NUM_EXT-1:0] rise);
        logic t;
        t = 1'b0;
        unique case (psc)
            3'b000: t = 1'b1;
            3'b001: t = div_tick(pre, DIV4_BITS);
            3'b010: t = div_tick(pre, DIV16_BITS);
            3'b011: t = div_tick(pre, DIV64_BITS);
            3'b100: t = rise[0];
            3'b101: t = rise[1];
            3'b110: begin
                if (ch == 1) begin
                    t = div_tick(pre, DIV256_BITS);
                end else begin
                    t = rise[2];
                end
            end
            3'b111: begin
                if (ch == 0) begin
                    t = rise[3];
                end else if (ch == 2) begin
                    t = div_tick(pre, DIV1024_BITS);
                end else begin
                    t = 1'b0;
                end
            end
        endcase
        return t;
    endfunction

    function automatic logic is_phase(input int ch, input logic [7:0] mode);
        op_mode_t m;
        m = op_mode_t'(mode[OPM_MSB:OPM_LSB]);
        // Prohibited codes and channel 0 fall back to plain counting
        return (ch != 0) && (m inside {OPM_PHASE1, OPM_PHASE2, OPM_PHASE3, OPM_PHASE4});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [NUM_EXT-1:0] ext_level;
    logic [NUM_EXT-1:0] ext_rise;
    logic [PRE_W-1:0] pre;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] sync_en;
    logic [7:0] ctrl [NUM_CH];
    logic [7:0] mode [NUM_CH];
    logic [15:0] count [NUM_CH];
    logic [15:0] gr [NUM_CH][NUM_GR];

    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0] down;
    logic [NUM_GR-1:0] hit [NUM_CH];
    logic [NUM_CH-1:0] own_clear;
    logic [NUM_CH-1:0] clear;
    logic sync_source;

    logic page_hit;
    logic [1:0] sel_ch;
    logic [3:0] sel_reg;
    logic [15:0] next_rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Phase pin pair: A/B for channel 1, C/D for channel 2
    function automatic int phase_pin(input int ch);
        return (ch == 2) ? 2 : 0;
    endfunction

    // Bus write to one register of one channel page
    function automatic logic reg_write(input int ch, input logic [3:0] ofs);
        return wr_en && page_hit && (sel_ch == 2'(ch)) && (sel_reg == ofs);
    endfunction

    pin_sync u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pin_raw({ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a}),
        .pin_level(ext_level),
        .pin_rise(ext_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb begin
        page_hit = (addr[7:6] == 2'b00) && (addr[5:4] != 2'b00);
        sel_ch = addr[5:4] - CH0_PAGE;
        sel_reg = addr[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count clocks, matches and clearing

    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (is_phase(ch, mode[ch])) begin
                // Phase pair: A/B on channel 1, C/D on channel 2
                tick[ch] = run[ch] && ext_rise[phase_pin(ch)];
                down[ch] = ext_level[phase_pin(ch) + 1];
            end else begin
                tick[ch] = run[ch] && clock_tick(ch, ctrl[ch][PSC_MSB:PSC_LSB], pre, ext_rise);
                down[ch] = 1'b0;
            end
            for (int r = 0; r < NUM_GR; r++) begin
                hit[ch][r] = tick[ch] && (count[ch] == gr[ch][r]);
            end
            if (ch != 0) begin
                hit[ch][2] = 1'b0;
                hit[ch][3] = 1'b0;
            end else begin
                if (mode[ch][BUF_A_BIT]) begin
                    hit[ch][2] = 1'b0;
                end
                if (mode[ch][BUF_B_BIT]) begin
                    hit[ch][3] = 1'b0;
                end
            end
            unique case (clr_sel_t'(ctrl[ch][CLR_MSB:CLR_LSB]))
                CLR_A: own_clear[ch] = hit[ch][0];
                CLR_B: own_clear[ch] = hit[ch][1];
                CLR_C: own_clear[ch] = hit[ch][2];
                CLR_D: own_clear[ch] = hit[ch][3];
                default: own_clear[ch] = 1'b0;
            endcase
        end
        sync_source = |(own_clear & sync_en);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            clear[ch] = own_clear[ch] ||
                (sync_en[ch] && (ctrl[ch][CLR_LSB+1:CLR_LSB] == 2'b11) && sync_source);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    always_ff @(posedge clk) begin
        if (rst) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start and sync registers

    always_ff @(posedge clk) begin
        if (rst) begin
            run <= '0;
            sync_en <= '0;
        end else if (wr_en && addr == START_OFS) begin
            run <= wr_data[NUM_CH-1:0];
        end else if (wr_en && addr == SYNC_OFS) begin
            sync_en <= wr_data[NUM_CH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and mode registers

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                ctrl[ch] <= CTRL_RESET;
                mode[ch] <= MODE_RESET;
            end
        end else if (wr_en && page_hit && sel_ch < NUM_CH) begin
            if (sel_reg == CTRL_OFS) begin
                if (sel_ch == 2'd0) begin
                    ctrl[sel_ch] <= wr_data[7:0];
                end else begin
                    ctrl[sel_ch] <= wr_data[7:0] & CTRL_CH12_MASK;
                end
            end
            if (sel_reg == MODE_OFS) begin
                // Accepted at any time; the counter is expected to be stopped
                if (sel_ch == 2'd0) begin
                    mode[sel_ch] <= MODE_ONES | (wr_data[7:0] & MODE_CH0_MASK);
                end else begin
                    mode[sel_ch] <= MODE_ONES | (wr_data[7:0] & MODE_CH12_MASK);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counters

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                count[ch] <= COUNT_RESET;
            end
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (reg_write(ch, COUNT_OFS)) begin
                    count[ch] <= wr_data;
                end else if (clear[ch]) begin
                    count[ch] <= COUNT_RESET;
                end else if (tick[ch] && down[ch]) begin
                    count[ch] <= count[ch] - 16'h0001;
                end else if (tick[ch]) begin
                    count[ch] <= count[ch] + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General registers with buffer transfer

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                for (int r = 0; r < NUM_GR; r++) begin
                    gr[ch][r] <= GR_RESET;
                end
            end
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                for (int r = 0; r < NUM_GR; r++) begin
                    if (reg_write(ch, GR_A_OFS + 4'(r)) && (ch == 0 || r < 2)) begin
                        gr[ch][r] <= wr_data;
                    end
                end
            end
            if (mode[0][BUF_A_BIT] && hit[0][0]) begin
                gr[0][0] <= gr[0][2];
            end
            if (mode[0][BUF_B_BIT] && hit[0][1]) begin
                gr[0][1] <= gr[0][3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event outputs

    always_ff @(posedge clk) begin
        if (rst) begin
            compare_match <= '0;
            counter_cleared <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                for (int r = 0; r < NUM_GR; r++) begin
                    compare_match[ch*NUM_GR+r] <= hit[ch][r];
                end
            end
            counter_cleared <= clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        next_rd_data = 16'h0000;
        if (addr == START_OFS) begin
            next_rd_data = {13'h0000, run};
        end else if (addr == SYNC_OFS) begin
            next_rd_data = {13'h0000, sync_en};
        end else if (page_hit && sel_ch < NUM_CH) begin
            if (sel_reg == CTRL_OFS) begin
                next_rd_data = {8'h00, ctrl[sel_ch]};
            end else if (sel_reg == MODE_OFS) begin
                next_rd_data = {8'h00, mode[sel_ch]};
            end else if (sel_reg == COUNT_OFS) begin
                next_rd_data = count[sel_ch];
            end else if (sel_reg >= GR_A_OFS && sel_reg <= GR_D_OFS) begin
                if (sel_ch == 2'd0 || sel_reg < GR_A_OFS + 4'h2) begin
                    next_rd_data = gr[sel_ch][2'(sel_reg - GR_A_OFS)];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 16'h0000;
        end
    end

endmodule // timer_channel_clock_clear_mode_config

// ===== verif/timer_cfg_asserts.sv
module timer_cfg_asserts
    import timer_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rd_data,
    // Events
    input wire logic [NUM_CH*NUM_GR-1:0] compare_match,
    input wire logic [NUM_CH-1:0] counter_cleared
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////
    // Shadow of written settings
    logic [2:0] clr0;
    logic [1:0] clr1;
    logic [1:0] sync_en;
    logic buf_a0;
    logic buf_b0;
    logic cd_off;
    assign cd_off = (buf_a0 && clr0 == 3'b101) || (buf_b0 && clr0 == 3'b110);
    always_ff @(posedge clk) begin
        if (rst) begin
            clr0 <= 3'b000;
            clr1 <= 2'b00;
            sync_en <= 2'b00;
            buf_a0 <= 1'b0;
            buf_b0 <= 1'b0;
        end else if (wr_en) begin
            if (addr == 8'h01) sync_en <= wr_data[1:0];
            if (addr == 8'h10) clr0 <= wr_data[7:5];
            if (addr == 8'h11) {buf_b0, buf_a0} <= wr_data[5:4];
            if (addr == 8'h20) clr1 <= wr_data[6:5];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
        else $error("read data not idle");
    AST_CTRL_BIT7: assert property ($past(rd_en) && $past(addr) inside {8'h20, 8'h30} |-> rd_data[15:7] == 9'h000)
        else $error("control bit 7 set");
    AST_MODE_FIXED: assert property ($past(rd_en) && $past(addr) inside {8'h21, 8'h31} |-> rd_data[7:4] == 4'hc)
        else $error("mode fixed bits wrong");
    AST_NO_CD: assert property (compare_match[7:6] == 2'b00 && compare_match[11:10] == 2'b00)
        else $error("missing register matched");
    AST_NO_CLEAR: assert property (counter_cleared[1] |-> $past(clr1) != 2'b00)
        else $error("clear while disabled");
    AST_A_CLEARS: assert property (compare_match[4] && $past(clr1) == 2'b01 |-> counter_cleared[1])
        else $error("match did not clear");
    AST_SYNC_NEEDED: assert property (counter_cleared[1] && $past(clr1) == 2'b11 |-> $past(sync_en[1]))
        else $error("sync clear without sync bit");
    AST_BUF_QUIET: assert property (!($past(buf_a0) && compare_match[2]) && !($past(buf_b0) && compare_match[3]))
        else $error("buffer register matched");
    AST_BUF_NO_CLEAR: assert property (counter_cleared[0] |-> !$past(cd_off))
        else $error("buffer register cleared");
endmodule // timer_cfg_asserts

bind timer_channel_clock_clear_mode_config timer_cfg_asserts u_timer_cfg_asserts (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .compare_match(compare_match),
    .counter_cleared(counter_cleared)
);

// ===== verif/tb_timer_channel_clock_clear_mode_config.sv
module tb_timer_channel_clock_clear_mode_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [15:0] rd_data;
    logic [11:0] compare_match;
    logic [2:0] counter_cleared;
    logic [31:0] seed = 32'd50;
    logic [15:0] got;
    logic [15:0] d;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int c;
    int p;
    int g;

    always #20 clk = ~clk;

    timer_channel_clock_clear_mode_config u_timer_channel_clock_clear_mode_config (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .ext_clock_in_a(pins[0]),
        .ext_clock_in_b(pins[1]),
        .ext_clock_in_c(pins[2]),
        .ext_clock_in_d(pins[3]),
        .compare_match(compare_match),
        .counter_cleared(counter_cleared)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] pg(int ch);
        return 8'(16 * ch + 16);
    endfunction
    function automatic logic [15:0] exp_reg(int ch, logic is_mode, logic [15:0] v);
        if (is_mode) return {8'h00, 8'hc0 | (v[7:0] & (ch == 0 ? 8'h3f : 8'h0f))};
        return {8'h00, ch == 0 ? v[7:0] : v[7:0] & 8'h7f};
    endfunction
    function automatic int clr_hi(int c, int g);
        if (c % 4 == 1) return g;
        if (c % 4 == 2) return g + 10;
        if (c == 3) return 5;
        return 70;
    endfunction
    task automatic wr(logic [7:0] a, logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        got = rd_data;
    endtask
    task automatic pulses();
        for (int i = 0; i < 9; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (i < 3 + 2 * j) begin
                    pins[j] <= 1'b1;
                    repeat (4) @(posedge clk);
                    pins[j] <= 1'b0;
                    repeat (4) @(posedge clk);
                end
            end
        end
    endtask
    task automatic run(logic [2:0] m, int n, logic ext);
        wr(8'h00, {13'h0000, m});
        if (ext) pulses();
        repeat (n) @(posedge clk);
        wr(8'h00, 16'h0000);
    endtask
    task automatic chk_eq(string name, logic [15:0] e, logic [15:0] a);
        checks_done++;
        if (a !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, e, a);
        end
    endtask
    task automatic chk_rng(string name, int lo, int hi, logic [15:0] a);
        checks_done++;
        if ($isunknown(a) || a < lo || a > hi) begin
            mismatches++;
            $display("Error %s expected %0d to %0d seen %h", name, lo, hi, a);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped place
        for (c = 0; c < 3; c++) begin
            rd(pg(c) + 8'h01);
            chk_eq("mode reset", 16'h00c0, got);
        end
        wr(8'h0f, 16'hffff);
        rd(8'h0f);
        chk_eq("unmapped", 16'h0000, got);
        // Random control and mode writes
        for (int i = 0; i < 12; i++) begin
            c = i % 3;
            d = 16'(rnd());
            if (c == 1 && d[2:0] == 3'b111) d[0] = 1'b0;
            wr(pg(c), d);
            rd(pg(c));
            chk_eq("ctrl", exp_reg(c, 1'b0, d), got);
            d = 16'(rnd()) & (c == 0 ? 16'hfff3 : 16'hfff7);
            wr(pg(c) + 8'h01, d);
            rd(pg(c) + 8'h01);
            chk_eq("mode", exp_reg(c, 1'b1, d), got);
        end
        for (c = 0; c < 3; c++) begin
            wr(pg(c), 16'h0000);
            wr(pg(c) + 8'h01, 16'h0000);
        end
        // Internal prescaler on every channel
        for (int k = 0; k < 14; k++) begin
            c = k < 12 ? k % 3 : k - 11;
            p = k < 12 ? k / 3 : k - 6;
            wr(pg(c) + 8'h02, 16'h0000);
            wr(pg(c), 16'(p));
            run(3'(1 << c), 8 << (p < 6 ? 2 * p : 2 * p - 4), 1'b0);
            rd(pg(c) + 8'h02);
            chk_rng("int count", 7, 11, got);
        end
        // External clock pins
        for (c = 0; c < 3; c++) begin
            for (p = 4; p < (c == 0 ? 8 : c == 1 ? 6 : 7); p++) begin
                wr(pg(c) + 8'h02, 16'h0000);
                wr(pg(c), 16'(p));
                run(3'(1 << c), 8, 1'b1);
                rd(pg(c) + 8'h02);
                chk_eq("ext count", 16'(2 * p - 5), got);
            end
        end
        // Clear select on channel 1, channel 0 clears at 5
        wr(8'h14, 16'h0005);
        wr(8'h10, 16'h0020);
        for (c = 0; c < 8; c++) begin
            g = 2 + int'(rnd() % 8);
            wr(8'h24, 16'(g));
            wr(8'h25, 16'(g + 10));
            wr(8'h20, 16'(c % 4) << 5);
            wr(8'h01, c == 3 ? 16'h0003 : 16'h0000);
            wr(8'h12, 16'h0000);
            wr(8'h22, 16'h0000);
            run(3'b011, 60, 1'b0);
            rd(8'h22);
            chk_rng("clr count", (c % 4 == 0 || c == 7) ? 55 : 0, clr_hi(c, g), got);
        end
        // Buffer pairs on channel 0
        wr(8'h14, 16'd200);
        wr(8'h15, 16'd200);
        wr(8'h16, 16'd3);
        wr(8'h17, 16'd3);
        for (int b = 0; b < 2; b++) begin
            wr(8'h11, b ? 16'h0020 : 16'h0010);
            wr(8'h10, b ? 16'h00c0 : 16'h00a0);
            wr(8'h12, 16'h0000);
            run(3'b001, 30, 1'b0);
            rd(8'h12);
            chk_rng("buf count", 25, 40, got);
        end
        // Buffer transfer: A takes C, B takes D at their match
        for (int b = 0; b < 2; b++) begin
            wr(8'h11, b ? 16'h0020 : 16'h0010);
            wr(8'h14 + 8'(b), 16'd5);
            wr(8'h16 + 8'(b), 16'd9);
            wr(8'h10, b ? 16'h0040 : 16'h0020);
            wr(8'h12, 16'h0000);
            run(3'b001, 20, 1'b0);
            rd(8'h14 + 8'(b));
            chk_eq("buf transfer", 16'd9, got);
        end
        // Phase counting ignores prescaler
        for (c = 1; c < 3; c++) begin
            wr(pg(c) + 8'h01, 16'h0004);
            wr(pg(c), 16'h0000);
            wr(pg(c) + 8'h02, 16'h0000);
            run(3'(1 << c), 8, 1'b1);
            rd(pg(c) + 8'h02);
            chk_eq("phase count", c == 1 ? 16'd3 : 16'd7, got);
        end
        print_verdict();
    end
endmodule // tb_timer_channel_clock_clear_mode_config
